//--- rtl/uart_rx_ts.sv
/*
 * Serial receiver with per-character error byte and silence timestamp,
 * a 16-record receive buffer and a plain register port.
 * Assumes i_rxd already synchronous to i_clk, idle high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_defs.svh"

// Behaviour
// - twelve baud rates, 115200 default
// - parity odd even mark space none
// - five to eight data bits, eight default
// - stop length limited by character length
// - line type selectable, rs485 default
// - extended mode record, normal data only
// - data byte holds received bits
// - error bit0 marks invalid character
// - error bit3 break over one character
// - error bit4 framing, low stop bit
// - error bit5 parity mismatch
// - error bit6 fifo overrun, first read
// - error bit7 written into full buffer
// - silence restarts at char, config, tx
// - current silence readable by software
// - interrupt at 1, 4, 8, 14 bytes
module uart_rx_ts (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic        i_rxd,
    input  wire logic        i_tx_done,
    output logic      [31:0] o_rdata,
    output logic             o_irq,
    output logic             o_rs485
);
    import uart_rx_pkg::*;

    logic [15:0]        cfg_q;
    rx_state_e          state_q;
    logic [15:0]        div_q;
    logic [3:0]         cnt_q;
    logic [2:0]         bitn_q;
    logic [7:0]         sh_q;
    logic               rxd_q;
    logic               zero_q;
    logic               perr_q;
    logic [15:0]        ts_q;
    logic [15:0]        sil_q;
    logic [8:0]         unit_q;
    logic [31:0]        mem [`BUF_DEPTH];
    logic [3:0]         wp_q;
    logic [3:0]         rp_q;
    logic [4:0]         fill_q;
    logic               ovr_q;

    logic        tick;
    logic        fall;
    logic        push;
    logic        pop;
    logic        full;
    logic        cfg_wr;
    logic [2:0]  nbits_m1;
    logic [7:0]  data_al;
    logic        exp_par;
    logic        ferr;
    logic        brk;
    logic [7:0]  err;
    logic [3:0]  xstop_end;
    logic [4:0]  thr;
    logic [31:0] rec;

    assign cfg_wr   = i_wr && (i_addr == `ADDR_CFG);
    assign fall     = rxd_q && !i_rxd;
    assign tick     = (div_q == baud_div(cfg_q[`CFG_BAUD]) - 16'h1);
    assign nbits_m1 = {1'b1, cfg_q[`CFG_BITS]};
    // lsb-first shift lands short characters high; realign
    assign data_al  = sh_q >> (3'h7 - nbits_m1);

    always_comb begin
        case (cfg_q[`CFG_PAR])
            `PAR_ODD:   exp_par = ~^data_al;
            `PAR_EVEN:  exp_par = ^data_al;
            `PAR_MARK:  exp_par = 1'b1;
            default:    exp_par = 1'b0;
        endcase
    end

    // 1.5 stop with five bits, 2 otherwise; illegal pairs map the same way
    assign xstop_end = (cfg_q[`CFG_BITS] == 2'h0) ? 4'h7 : 4'hf;

    always_comb begin
        case (cfg_q[`CFG_THR])
            2'h0:    thr = 5'd1;
            2'h1:    thr = 5'd4;
            2'h2:    thr = 5'd8;
            default: thr = 5'd14;
        endcase
    end

    assign ferr = !i_rxd;
    // line low through start, all data, parity and first stop
    assign brk  = !i_rxd && zero_q;
    assign push = (state_q == st_stop) && tick && (cnt_q == 4'hf);
    assign full = (fill_q == 5'(`BUF_DEPTH));
    assign pop  = i_rd && (i_addr == `ADDR_RXREC) && (fill_q != 5'h0);

    always_comb begin
        err                = 8'h00;
        err[`ERR_BREAK]    = brk;
        err[`ERR_FRAME]    = ferr;
        err[`ERR_PARITY]   = perr_q;
        err[`ERR_BUF_OVR]  = full && !pop;
        err[`ERR_INVALID]  = |err[7:3];
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cfg_q <= `CFG_RESET;
        end else if (cfg_wr) begin
            cfg_q <= i_wdata[15:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rxd_q <= 1'b1;
        end else begin
            rxd_q <= i_rxd;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || ((state_q == st_idle) && fall) || tick) begin
            div_q <= 16'h0;
        end else begin
            div_q <= div_q + 16'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || cfg_wr) begin
            state_q <= st_idle;
            cnt_q   <= 4'h0;
            bitn_q  <= 3'h0;
            sh_q    <= 8'h00;
            zero_q  <= 1'b0;
            perr_q  <= 1'b0;
            ts_q    <= 16'h0;
        end else begin
            case (state_q)
                st_idle: begin
                    if (fall) begin
                        state_q <= st_start;
                        cnt_q   <= 4'h0;
                        ts_q    <= sil_q;
                    end
                end
                st_start: begin
                    if (tick) begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'h7) begin
                            // a glitch shorter than half a bit is not a start
                            state_q <= i_rxd ? st_idle : st_data;
                            cnt_q   <= 4'h0;
                            bitn_q  <= 3'h0;
                            sh_q    <= 8'h00;
                            zero_q  <= 1'b1;
                            perr_q  <= 1'b0;
                        end
                    end
                end
                st_data: begin
                    if (tick) begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'hf) begin
                            sh_q   <= {i_rxd, sh_q[7:1]};
                            zero_q <= zero_q && !i_rxd;
                            bitn_q <= bitn_q + 3'h1;
                            if (bitn_q == nbits_m1) begin
                                state_q <= (cfg_q[`CFG_PAR] == `PAR_NONE) ? st_stop : st_par;
                            end
                        end
                    end
                end
                st_par: begin
                    if (tick) begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'hf) begin
                            perr_q  <= (i_rxd != exp_par);
                            zero_q  <= zero_q && !i_rxd;
                            state_q <= st_stop;
                        end
                    end
                end
                st_stop: begin
                    if (tick) begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'hf) begin
                            cnt_q <= 4'h0;
                            if (!i_rxd) begin
                                state_q <= st_brk;
                            end else if (cfg_q[`CFG_STOP] != `STOP_ONE) begin
                                state_q <= st_xstop;
                            end else begin
                                state_q <= st_idle;
                            end
                        end
                    end
                end
                st_xstop: begin
                    if (tick) begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == xstop_end) begin
                            state_q <= st_idle;
                        end
                    end
                end
                st_brk: begin
                    // no new start until the line has returned to mark
                    if (i_rxd) begin
                        state_q <= st_idle;
                    end
                end
                default: state_q <= st_idle;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || push || cfg_wr || i_tx_done) begin
            unit_q <= 9'h0;
        end else if (unit_q == 9'(`SIL_UNIT_CYC - 1)) begin
            unit_q <= 9'h0;
        end else begin
            unit_q <= unit_q + 9'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || push || cfg_wr || i_tx_done) begin
            sil_q <= 16'h0;
        end else if ((unit_q == 9'(`SIL_UNIT_CYC - 1)) && (sil_q != `SIL_MAX)) begin
            sil_q <= sil_q + 16'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp_q] <= {ts_q, err, data_al};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || cfg_wr) begin
            wp_q   <= 4'h0;
            rp_q   <= 4'h0;
            fill_q <= 5'h0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 4'h1;
            end
            // a push into a full buffer drops the oldest record
            if (pop || (push && full)) begin
                rp_q <= rp_q + 4'h1;
            end
            if (push && !pop && !full) begin
                fill_q <= fill_q + 5'h1;
            end else if (pop && !push) begin
                fill_q <= fill_q - 5'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || cfg_wr) begin
            ovr_q <= 1'b0;
        end else if (push && full && !pop) begin
            ovr_q <= 1'b1;
        end else if (pop) begin
            ovr_q <= 1'b0;
        end
    end

    always_comb begin
        rec = mem[rp_q];
        if (ovr_q) begin
            rec[8 + `ERR_FIFO_OVR] = 1'b1;
            rec[8 + `ERR_INVALID]  = 1'b1;
        end
        if (!cfg_q[`CFG_EXT]) begin
            rec[31:8] = 24'h0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h0;
        end else if (i_rd) begin
            case (i_addr)
                `ADDR_CFG:     o_rdata <= {16'h0, cfg_q};
                `ADDR_STATUS:  o_rdata <= {16'h0, 4'h0, state_q != st_idle, o_irq, ovr_q,
                                          fill_q};
                `ADDR_RXREC:   o_rdata <= (fill_q != 5'h0) ? rec : 32'h0;
                `ADDR_SILENCE: o_rdata <= {16'h0, sil_q};
                default:       o_rdata <= 32'h0;
            endcase
        end else begin
            o_rdata <= 32'h0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= (fill_q >= thr);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rs485 <= 1'b1;
        end else begin
            o_rs485 <= cfg_q[`CFG_RS485];
        end
    end
endmodule : uart_rx_ts
`default_nettype wire

//--- rtl/uart_rx_defs.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * timestamping serial receiver. Assumes a 50 MHz system clock.
 */
`ifndef UART_RX_DEFS_SVH
`define UART_RX_DEFS_SVH

`define CLK_HZ        50000000
`define CLK_NS        20
`define SIL_UNIT_NS   10000
`define SIL_UNIT_CYC  (`SIL_UNIT_NS / `CLK_NS)
`define OVERSAMPLE    16

`define ADDR_CFG      8'h00
`define ADDR_STATUS   8'h04
`define ADDR_RXREC    8'h08
`define ADDR_SILENCE  8'h0c

`define CFG_BAUD      3:0
`define CFG_PAR       6:4
`define CFG_BITS      9:8
`define CFG_STOP      11:10
`define CFG_RS485     12
`define CFG_EXT       13
`define CFG_THR       15:14
`define CFG_RESET     16'h930b

`define PAR_NONE      3'h0
`define PAR_ODD       3'h1
`define PAR_EVEN      3'h2
`define PAR_MARK      3'h3
`define PAR_SPACE     3'h4

`define STOP_ONE      2'h0

`define ERR_INVALID   0
`define ERR_BREAK     3
`define ERR_FRAME     4
`define ERR_PARITY    5
`define ERR_FIFO_OVR  6
`define ERR_BUF_OVR   7

`define BUF_DEPTH     16
`define SIL_MAX       16'hffff

`endif

//--- rtl/uart_rx_pkg.sv
/*
 * Types of the timestamping serial receiver: receive states and the
 * baud divisor lookup. Assumes uart_rx_defs.svh is on the include path.
 */
`include "uart_rx_defs.svh"

package uart_rx_pkg;
    typedef enum logic [2:0] {
        st_idle, st_start, st_data, st_par, st_stop, st_xstop, st_brk
    } rx_state_e;

    typedef logic [15:0] div_t;

    // clocks per oversample tick, truncated
    function automatic div_t baud_div(input logic [3:0] sel);
        int baud;
        case (sel)
            4'h0:    baud = 200;
            4'h1:    baud = 300;
            4'h2:    baud = 600;
            4'h3:    baud = 1200;
            4'h4:    baud = 1800;
            4'h5:    baud = 2400;
            4'h6:    baud = 4800;
            4'h7:    baud = 9600;
            4'h8:    baud = 19200;
            4'h9:    baud = 38400;
            4'ha:    baud = 57600;
            default: baud = 115200;
        endcase
        return div_t'(`CLK_HZ / (baud * `OVERSAMPLE));
    endfunction : baud_div
endpackage : uart_rx_pkg

//--- test/uart_rx_ts_monitor.sv
/* checker of the receiver's register port, line type and irq level.
   sees only the top ports; bound from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_defs.svh"
module uart_rx_ts_monitor (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic        o_irq,
    input wire logic        o_rs485
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic cfg_wr = i_wr && i_addr == `ADDR_CFG;
    sequence s_cfg_wr; cfg_wr; endsequence
    sequence s_cfg_rd; i_rd && !i_wr && i_addr == `ADDR_CFG; endsequence
    property p_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
    property p_unmap;
        i_rd && !(i_addr inside {`ADDR_CFG, `ADDR_STATUS, `ADDR_RXREC, `ADDR_SILENCE})
            |=> o_rdata == 32'h0;
    endproperty
    property p_back; s_cfg_wr ##1 s_cfg_rd |=> o_rdata[15:0] == $past(i_wdata[15:0], 2);
    endproperty
    property p_set; cfg_wr && i_wdata[12] |-> ##[1:2] o_rs485; endproperty
    property p_clr; cfg_wr && !i_wdata[12] |-> ##[1:2] !o_rs485; endproperty
    property p_cause; $changed(o_rs485) |-> $past(cfg_wr) || $past(cfg_wr, 2); endproperty
    property p_flush; s_cfg_wr |-> ##[1:3] !o_irq; endproperty
    property p_stat; i_rd && i_addr == `ADDR_STATUS && o_irq ##1 o_irq |-> o_rdata[6];
    endproperty
    property p_sil; i_rd && i_addr == `ADDR_SILENCE |=> o_rdata[31:16] == 16'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read slot");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_back: assert property (p_back) else $error("config readback differs");
    a_set: assert property (p_set) else $error("line type not rs485");
    a_clr: assert property (p_clr) else $error("line type not rs422");
    a_cause: assert property (p_cause) else $error("line type moved alone");
    a_flush: assert property (p_flush) else $error("irq kept after config");
    a_stat: assert property (p_stat) else $error("status irq bit wrong");
    a_sil: assert property (p_sil) else $error("silence wider than 16 bits");
endmodule : uart_rx_ts_monitor
`default_nettype wire

//--- test/serial_station.sv
/* remote station on the receive line, one bit per BIT_CLKS clocks.
   assumes calls start at a rising edge; line is biased high when idle. */
`timescale 1ns/1ps
`default_nettype none
module serial_station #(
    parameter int BIT_CLKS = 432
) (
    input  wire logic i_clk,
    output logic      o_line
);
    initial o_line = 1'b1;
    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
    endtask : hold
    // halves: stop time in half bits; a low stop forces framing or break
    task automatic send(input logic [7:0] d, input int nb, input logic pe,
                        input logic pb, input logic stop_lvl, input int halves);
        o_line <= 1'b0;
        hold(BIT_CLKS);
        for (int i = 0; i < nb; i++) begin
            o_line <= d[i];
            hold(BIT_CLKS);
        end
        if (pe) begin
            o_line <= pb;
            hold(BIT_CLKS);
        end
        o_line <= stop_lvl;
        hold(halves * BIT_CLKS / 2);
        o_line <= 1'b1;
    endtask : send
endmodule : serial_station
`default_nettype wire

//--- test/uart_rx_ts_test.sv
/* self-checking bench of the timestamping receiver: reads queue their
   expectation, a watcher compares one cycle later. assumes 115200 baud. */
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_defs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module uart_rx_ts_test;
    logic        i_clk, i_rst_n, i_wr, i_rd, i_tx_done, rd_d, o_irq, o_rs485, pb;
    logic [7:0]  i_addr, d;
    logic [31:0] i_wdata, o_rdata;
    logic [63:0] x;
    logic [63:0] expq[$];
    wire logic   line;
    int          err_count, total_checks;
    uart_rx_ts dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_rxd(line), .i_tx_done(i_tx_done),
        .o_rdata(o_rdata), .o_irq(o_irq), .o_rs485(o_rs485));
    serial_station stn (.i_clk(i_clk), .o_line(line));
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v,
                       input logic [31:0] m);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= v;
        if (!w) expq.push_back({m, v & m});
        @(posedge i_clk);
    endtask : bus
    task automatic idle();
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        @(posedge i_clk);
    endtask : idle
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, e, m);
        idle();
    endtask : rd
    task automatic cfg(input logic [31:0] v);
        bus(1'b1, `ADDR_CFG, v, 32'h0);
        idle();
    endtask : cfg
    task automatic peek(input logic e_irq, input logic e_485);
        @(negedge i_clk);
        `CHK(o_irq, e_irq)
        `CHK(o_rs485, e_485)
        @(posedge i_clk);
    endtask : peek
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    always @(posedge i_clk) rd_d <= i_rd;
    always @(negedge i_clk) begin
        if (rd_d === 1'b1 && expq.size() > 0) begin
            x = expq.pop_front();
            `CHK(o_rdata & x[63:32], x[31:0])
        end
    end
    initial begin
        repeat (95000) @(posedge i_clk);
        err_count++;
        stop_test();
    end
    initial begin
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h0;
        i_wdata = 32'h0;
        i_tx_done = 1'b0;
        void'($urandom(33));
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        peek(1'b0, 1'b1);
        rd(`ADDR_CFG, 32'h930b, 32'hffff);
        rd(8'h10, 32'h0, '1);
        rd(`ADDR_STATUS, 32'h0, 32'h1f);
        bus(1'b1, `ADDR_CFG, 32'h230b, 32'h0);
        bus(1'b0, `ADDR_CFG, 32'h230b, 32'hffff);
        idle();
        repeat (1250) @(posedge i_clk);
        stn.send(8'ha5, 8, 1'b0, 1'b0, 1'b1, 2);
        peek(1'b1, 1'b0);
        rd(`ADDR_RXREC, 32'h0002_00a5, '1);
        // every parity mode but none, once good and once corrupted
        for (int p = 1; p <= 4; p++) begin
            cfg(32'h220b | (p << 4));
            for (int k = 0; k < 2; k++) begin
                d = 8'($urandom()) & 8'h7f;
                pb = (p == 1) ? ~^d : (p == 2) ? ^d : (p == 3);
                stn.send(d, 7, 1'b1, pb ^ k[0], 1'b1, 2);
                rd(`ADDR_RXREC, {8'h0, k ? 8'h21 : 8'h00, d}, 32'hffffff);
            end
        end
        cfg(32'h230b);
        stn.send(8'h5a, 8, 1'b0, 1'b0, 1'b0, 2);
        rd(`ADDR_RXREC, 32'h115a, 32'hffffff);
        stn.send(8'h00, 8, 1'b0, 1'b0, 1'b0, 2);
        rd(`ADDR_RXREC, 32'h1900, 32'hffffff);
        cfg(32'h240b);
        stn.send(8'h16, 5, 1'b0, 1'b0, 1'b1, 3);
        rd(`ADDR_RXREC, 32'h0016, 32'hffffff);
        cfg(32'h530b);
        for (int k = 0; k < 4; k++) begin
            peek(1'b0, 1'b1);
            stn.send(8'h30 + k, 8, 1'b0, 1'b0, 1'b1, 2);
        end
        peek(1'b1, 1'b1);
        rd(`ADDR_STATUS, 32'h44, 32'hff);
        for (int k = 0; k < 4; k++) rd(`ADDR_RXREC, 32'h30 + k, '1);
        i_tx_done <= 1'b1;
        @(posedge i_clk);
        i_tx_done <= 1'b0;
        repeat (1100) @(posedge i_clk);
        rd(`ADDR_SILENCE, 32'h2, '1);
        stop_test();
    end
endmodule : uart_rx_ts_test
bind uart_rx_ts uart_rx_ts_monitor mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_rs485(o_rs485));
`default_nettype wire
